/* src/rsai_pkg.sv */
// shared constants of the rtc status, alarm and interrupt block
package rsai_pkg;

  // ----------------------------------------------------------------
  // status register location and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_ADDR      = 16'h003F;
  localparam int          BIT_BACKUP       = 7;
  localparam int          BIT_ALARM1       = 6;
  localparam int          BIT_ALARM0       = 5;
  localparam int          BIT_REGISTER_WRITE_LATCH         = 2;
  localparam int          BIT_WEL          = 1;
  localparam int          BIT_PLOSS        = 0;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_WR_WEL    = 8'h02;
  localparam logic [7:0]  STATUS_WR_BOTH   = 8'h06;
  localparam logic [7:0]  STATUS_WR_CLEAR  = 8'h00;

  // ----------------------------------------------------------------
  // array protection ranges
  // ----------------------------------------------------------------
  localparam int          ARR_AW           = 11;
  localparam logic [10:0] ARR_TOP          = 11'h7FF;
  localparam logic [10:0] ARR_BASE         = 11'h000;
  localparam logic [10:0] PROT_Q_LO        = 11'h600;
  localparam logic [10:0] PROT_H_LO        = 11'h400;
  localparam logic [10:0] PROT_P1_HI       = 11'h03F;
  localparam logic [10:0] PROT_P2_HI       = 11'h07F;
  localparam logic [10:0] PROT_P4_HI       = 11'h0FF;
  localparam logic [10:0] PROT_P8_HI       = 11'h1FF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          PULSE_OSC_CYCLES = 1024;
  localparam int          PULSE_CW         = 11;
  localparam logic [1:0]  STARTUP_CYCLES   = 2'h3;

endpackage

/* src/rsai_sync.sv */
// two flip-flop level synchroniser
module rsai_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule

/* src/rsai_osc.sv */
// oscillator-domain alarm evaluation and interrupt pulse timer
module rsai_osc (
  input  wire logic osc_clk_in,
  input  wire logic rst_in,
  input  wire logic sec_tick_in,
  input  wire logic alarm0_match_in,
  input  wire logic alarm1_match_in,
  input  wire logic irq_pulse_select_in,
  output logic      alarm0_tgl_out,
  output logic      alarm1_tgl_out,
  output logic      pulse_active_out
);

  logic                                pulse_mode;
  logic [rsai_pkg::PULSE_CW-1:0]      pulse_cnt_reg;
  logic [rsai_pkg::PULSE_CW-1:0]      pulse_cnt_next;
  logic                                hit0;
  logic                                hit1;

  // ----------------------------------------------------------------
  // mode bit from the system domain
  // ----------------------------------------------------------------
  rsai_sync #(.WIDTH(1)) u_mode_sync (
    .clk_in (osc_clk_in),
    .rst_in (rst_in),
    .d_in   (irq_pulse_select_in),
    .q_out  (pulse_mode)
  );

  // ----------------------------------------------------------------
  // one evaluation per second update
  // ----------------------------------------------------------------
  assign hit0 = sec_tick_in & alarm0_match_in;
  assign hit1 = sec_tick_in & alarm1_match_in;

  assign pulse_cnt_next = (hit0 && pulse_mode) ?
                          rsai_pkg::PULSE_CW'(rsai_pkg::PULSE_OSC_CYCLES) :
                          (pulse_cnt_reg != '0) ? pulse_cnt_reg - 1'b1 : pulse_cnt_reg;

  always_ff @(posedge osc_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm0_tgl_out   <= 1'b0;
      alarm1_tgl_out   <= 1'b0;
      pulse_cnt_reg    <= '0;
      pulse_active_out <= 1'b0;
    end else begin
      if (hit0 && !pulse_mode) begin
        alarm0_tgl_out <= ~alarm0_tgl_out;
      end
      if (hit1) begin
        alarm1_tgl_out <= ~alarm1_tgl_out;
      end
      pulse_cnt_reg    <= pulse_cnt_next;
      pulse_active_out <= (pulse_cnt_next != '0);
    end
  end

endmodule

/* src/rsai_top.sv */
// status flags, write latches, block protect and alarm interrupt of the rtc
module rsai_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        osc_clk_in,
  input  wire logic        backup_supply_in,
  input  wire logic        total_loss_in,
  input  wire logic        sec_tick_in,
  input  wire logic        alarm0_match_in,
  input  wire logic        alarm1_match_in,
  input  wire logic        irq_pulse_select_in,
  input  wire logic        alarm1_irq_enable_in,
  input  wire logic        alarm0_irq_enable_in,
  input  wire logic [2:0]  protect_sel_in,
  input  wire logic        status_rd_start_in,
  input  wire logic        status_rd_done_in,
  input  wire logic        status_wr_in,
  input  wire logic [7:0]  status_wdata_in,
  input  wire logic        ccr_wr_in,
  input  wire logic        arr_wr_in,
  input  wire logic [10:0] arr_addr_in,
  output logic [7:0]       status_flags_out,
  output logic             wr_done_out,
  output logic             wr_ack_out,
  output logic             wr_commit_out,
  output logic             irq_out,
  output logic             irq_oe_out
);

  logic       backup_sync;
  logic       loss_sync;
  logic       tgl0_osc;
  logic       tgl1_osc;
  logic       tgl0_sync;
  logic       tgl1_sync;
  logic       pulse_osc;
  logic       pulse_sync;
  logic       tgl0_seen_reg;
  logic       tgl1_seen_reg;
  logic       alarm0_flag_reg;
  logic       alarm0_flag_next;
  logic       alarm1_flag_reg;
  logic       alarm1_flag_next;
  logic       snap0_reg;
  logic       snap1_reg;
  logic       register_write_latch_reg;
  logic       register_write_latch_next;
  logic       general_write_latch_reg;
  logic       general_write_latch_next;
  logic       power_loss_flag_reg;
  logic       power_loss_flag_next;
  logic [1:0] startup_reg;
  logic       startup_hit;
  logic       ev0;
  logic       ev1;
  logic       clr0;
  logic       clr1;
  logic       arr_prot;
  logic       ccr_ok;
  logic       arr_ok;
  logic       level_irq;
  logic       irq_active;
  logic [7:0] status_word;

  // ----------------------------------------------------------------
  // range check
  // ----------------------------------------------------------------
  function automatic logic in_prot(input logic [2:0] sel, input logic [10:0] a);
    logic [10:0] lo;
    logic [10:0] hi;
    logic        none;
    lo   = rsai_pkg::ARR_BASE;
    hi   = rsai_pkg::ARR_TOP;
    none = 1'b0;
    case (sel)
      3'h0: none = 1'b1;
      3'h1: lo = rsai_pkg::PROT_Q_LO;
      3'h2: lo = rsai_pkg::PROT_H_LO;
      3'h3: lo = rsai_pkg::ARR_BASE;
      3'h4: hi = rsai_pkg::PROT_P1_HI;
      3'h5: hi = rsai_pkg::PROT_P2_HI;
      3'h6: hi = rsai_pkg::PROT_P4_HI;
      3'h7: hi = rsai_pkg::PROT_P8_HI;
      default: none = 1'b1;
    endcase
    return !none && (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and domain crossings
  // ----------------------------------------------------------------
  rsai_sync #(.WIDTH(2)) u_pin_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({backup_supply_in, total_loss_in}),
    .q_out  ({backup_sync, loss_sync})
  );

  rsai_osc u_osc (
    .osc_clk_in          (osc_clk_in),
    .rst_in              (rst_in),
    .sec_tick_in         (sec_tick_in),
    .alarm0_match_in     (alarm0_match_in),
    .alarm1_match_in     (alarm1_match_in),
    .irq_pulse_select_in (irq_pulse_select_in),
    .alarm0_tgl_out      (tgl0_osc),
    .alarm1_tgl_out      (tgl1_osc),
    .pulse_active_out    (pulse_osc)
  );

  rsai_sync #(.WIDTH(3)) u_osc_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({tgl0_osc, tgl1_osc, pulse_osc}),
    .q_out  ({tgl0_sync, tgl1_sync, pulse_sync})
  );

  // ----------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------
  assign ev0  = tgl0_sync ^ tgl0_seen_reg;
  assign ev1  = tgl1_sync ^ tgl1_seen_reg;
  assign clr0 = status_rd_done_in & snap0_reg;
  assign clr1 = status_rd_done_in & snap1_reg;

  // set wins over clear; enables play no part in setting
  assign alarm0_flag_next = ev0 | (alarm0_flag_reg & ~clr0);
  assign alarm1_flag_next = ev1 | (alarm1_flag_reg & ~clr1);

  // ----------------------------------------------------------------
  // write latches and write gating
  // ----------------------------------------------------------------
  assign general_write_latch_next =
    (status_wr_in && status_wdata_in == rsai_pkg::STATUS_WR_WEL)   ? 1'b1 :
    (status_wr_in && status_wdata_in == rsai_pkg::STATUS_WR_BOTH)  ? 1'b1 :
    (status_wr_in && status_wdata_in == rsai_pkg::STATUS_WR_CLEAR) ? 1'b0 :
    general_write_latch_reg;

  assign register_write_latch_next =
    (status_wr_in && status_wdata_in == rsai_pkg::STATUS_WR_BOTH &&
     general_write_latch_reg) ? 1'b1 :
    (status_wr_in && status_wdata_in == rsai_pkg::STATUS_WR_CLEAR) ? 1'b0 :
    register_write_latch_reg;

  assign arr_prot = in_prot(protect_sel_in, arr_addr_in);
  assign ccr_ok   = ccr_wr_in & general_write_latch_reg & register_write_latch_reg;
  assign arr_ok   = arr_wr_in & general_write_latch_reg & ~arr_prot;

  // ----------------------------------------------------------------
  // power-loss flag
  // ----------------------------------------------------------------
  assign startup_hit = (startup_reg == rsai_pkg::STARTUP_CYCLES - 2'h1);
  assign power_loss_flag_next =
    (startup_hit && loss_sync) ? 1'b1 :
    ccr_ok ? 1'b0 : power_loss_flag_reg;

  // ----------------------------------------------------------------
  // interrupt and status composition
  // ----------------------------------------------------------------
  assign level_irq = (alarm0_flag_reg & alarm0_irq_enable_in) |
                     (alarm1_flag_reg & alarm1_irq_enable_in);
  assign irq_active = irq_pulse_select_in ? pulse_sync : level_irq;

  assign status_word = {backup_sync, alarm1_flag_reg, alarm0_flag_reg, 2'h0,
                        register_write_latch_reg, general_write_latch_reg,
                        power_loss_flag_reg};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl0_seen_reg            <= 1'b0;
      tgl1_seen_reg            <= 1'b0;
      alarm0_flag_reg          <= 1'b0;
      alarm1_flag_reg          <= 1'b0;
      snap0_reg                <= 1'b0;
      snap1_reg                <= 1'b0;
      general_write_latch_reg  <= 1'b0;
      register_write_latch_reg <= 1'b0;
      power_loss_flag_reg      <= 1'b0;
      startup_reg              <= 2'h0;
    end else begin
      tgl0_seen_reg            <= tgl0_sync;
      tgl1_seen_reg            <= tgl1_sync;
      alarm0_flag_reg          <= alarm0_flag_next;
      alarm1_flag_reg          <= alarm1_flag_next;
      if (status_rd_start_in) begin
        snap0_reg <= alarm0_flag_reg;
        snap1_reg <= alarm1_flag_reg;
      end else if (status_rd_done_in) begin
        snap0_reg <= 1'b0;
        snap1_reg <= 1'b0;
      end
      general_write_latch_reg  <= general_write_latch_next;
      register_write_latch_reg <= register_write_latch_next;
      power_loss_flag_reg      <= power_loss_flag_next;
      if (startup_reg != rsai_pkg::STARTUP_CYCLES) begin
        startup_reg <= startup_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_flags_out <= rsai_pkg::STATUS_RESET;
      wr_done_out      <= 1'b0;
      wr_ack_out       <= 1'b0;
      wr_commit_out    <= 1'b0;
      irq_out          <= 1'b0;
      irq_oe_out       <= 1'b0;
    end else begin
      status_flags_out <= status_word;
      wr_done_out      <= status_wr_in | ccr_wr_in | arr_wr_in;
      wr_ack_out       <= status_wr_in |
                          ((ccr_wr_in | arr_wr_in) & general_write_latch_reg);
      wr_commit_out    <= ccr_ok | arr_ok;
      irq_out          <= 1'b0;
      irq_oe_out       <= irq_active;
    end
  end

endmodule

/* verif/rsai_monitor.sv */
// assertion checker for the status, latch and interrupt block
module rsai_monitor (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       backup_supply_in,
  input wire logic       irq_pulse_select_in,
  input wire logic       alarm1_irq_enable_in,
  input wire logic [2:0] protect_sel_in,
  input wire logic       status_rd_start_in,
  input wire logic       status_rd_done_in,
  input wire logic       status_wr_in,
  input wire logic       ccr_wr_in,
  input wire logic       arr_wr_in,
  input wire logic [7:0] status_flags_out,
  input wire logic       wr_done_out,
  input wire logic       wr_ack_out,
  input wire logic       wr_commit_out,
  input wire logic       irq_out,
  input wire logic       irq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_any_wr;
    status_wr_in || ccr_wr_in || arr_wr_in;
  endsequence
  sequence s_rd;
    status_rd_start_in && status_flags_out[6] ##1 status_rd_done_in;
  endsequence
  property p_done;
    s_any_wr |=> wr_done_out;
  endproperty
  property p_nowel;
    (!status_wr_in)[*3] ##0 ((ccr_wr_in || arr_wr_in) && !status_flags_out[1])
      |=> !wr_ack_out && !wr_commit_out;
  endproperty
  property p_ccr;
    (!status_wr_in)[*3] ##0 (ccr_wr_in && status_flags_out[2:1] == 2'h3)
      |=> wr_ack_out && wr_commit_out;
  endproperty
  property p_ploss;
    ccr_wr_in ##1 wr_commit_out |=> !status_flags_out[0];
  endproperty
  property p_prot;
    arr_wr_in && protect_sel_in == 3'h3 && $stable(protect_sel_in) |=> !wr_commit_out;
  endproperty
  property p_zero;
    status_flags_out[4:3] == 2'h0 && !irq_out;
  endproperty
  property p_bak;
    ($stable(backup_supply_in))[*6] |-> status_flags_out[7] == backup_supply_in;
  endproperty
  property p_lvl;
    (!irq_pulse_select_in && alarm1_irq_enable_in && status_flags_out[6])[*3] |-> irq_oe_out;
  endproperty
  property p_rel;
    (!irq_pulse_select_in && status_flags_out[6:5] == 2'h0)[*3] |-> !irq_oe_out;
  endproperty
  property p_rd;
    s_rd |=> ##2 !status_flags_out[6];
  endproperty
  a_done: assert property (p_done) else $error("no ready after write");
  a_nowel: assert property (p_nowel) else $error("write taken without latch");
  a_ccr: assert property (p_ccr) else $error("enabled ccr write refused");
  a_ploss: assert property (p_ploss) else $error("loss flag kept");
  a_prot: assert property (p_prot) else $error("protected write stored");
  a_zero: assert property (p_zero) else $error("unused bits or pin data set");
  a_bak: assert property (p_bak) else $error("backup flag wrong");
  a_lvl: assert property (p_lvl) else $error("interrupt not driven");
  a_rel: assert property (p_rel) else $error("interrupt not released");
  a_rd: assert property (p_rd) else $error("flag not cleared by read");
endmodule

bind rsai_top rsai_monitor u_rsai_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .backup_supply_in(backup_supply_in),
  .irq_pulse_select_in(irq_pulse_select_in), .alarm1_irq_enable_in(alarm1_irq_enable_in),
  .protect_sel_in(protect_sel_in), .status_rd_start_in(status_rd_start_in),
  .status_rd_done_in(status_rd_done_in), .status_wr_in(status_wr_in),
  .ccr_wr_in(ccr_wr_in), .arr_wr_in(arr_wr_in), .status_flags_out(status_flags_out),
  .wr_done_out(wr_done_out), .wr_ack_out(wr_ack_out), .wr_commit_out(wr_commit_out),
  .irq_out(irq_out), .irq_oe_out(irq_oe_out));

/* verif/rsai_host_model.sv */
// host bus master model driving decoded write and read strobes
module rsai_host_model (
  input  wire logic  clk_in,
  output logic       status_wr_out,
  output logic [7:0] status_wdata_out,
  output logic       ccr_wr_out,
  output logic       arr_wr_out,
  output logic [10:0] arr_addr_out,
  output logic       rd_start_out,
  output logic       rd_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {status_wr_out, ccr_wr_out, arr_wr_out, rd_start_out, rd_done_out} = 5'h00;
    status_wdata_out = 8'h00;
    arr_addr_out = 11'h000;
  end
  // one write byte: 0 status, 1 clock/control, 2 array
  task automatic xfer(input logic [1:0] k, input logic [7:0] d, input logic [10:0] a);
    @(posedge clk_in);
    status_wdata_out <= d & 8'hE7;
    arr_addr_out <= a;
    status_wr_out <= (k == 2'h0);
    ccr_wr_out <= (k == 2'h1);
    arr_wr_out <= (k == 2'h2);
    @(posedge clk_in);
    {status_wr_out, ccr_wr_out, arr_wr_out} <= 3'h0;
    status_wdata_out <= ~d;
    arr_addr_out <= ~a;
  endtask
  // status byte read, gap cycles between start and eighth clock
  task automatic rd(input int gap);
    @(posedge clk_in);
    rd_start_out <= 1'b1;
    @(posedge clk_in);
    rd_start_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    rd_done_out <= 1'b1;
    @(posedge clk_in);
    rd_done_out <= 1'b0;
  endtask
endmodule

/* verif/rsai_top_tb_top.sv */
// self-checking bench for the status, latch and interrupt block
module rsai_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        osc_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        backup_supply_in = 1'b0;
  logic        total_loss_in = 1'b1;
  logic        sec_tick_in = 1'b0;
  logic        alarm0_match_in = 1'b0;
  logic        alarm1_match_in = 1'b0;
  logic        irq_pulse_select_in = 1'b0;
  logic        alarm1_irq_enable_in = 1'b0;
  logic        alarm0_irq_enable_in = 1'b0;
  logic [2:0]  protect_sel_in = 3'h0;
  logic        status_rd_start_in, status_rd_done_in, status_wr_in, ccr_wr_in, arr_wr_in;
  logic [7:0]  status_wdata_in, status_flags_out;
  logic [10:0] arr_addr_in, a;
  logic        wr_done_out, wr_ack_out, wr_commit_out, irq_out, irq_oe_out;
  logic [2:0]  exp_q[$];
  logic [2:0]  e;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  // ----------------------------------------------------------------
  // clocks, design and host
  // ----------------------------------------------------------------
  initial forever #25 clk_in = ~clk_in;
  initial #13 forever #40 osc_clk_in = ~osc_clk_in;
  rsai_top u_rsai_top (.clk_in(clk_in), .rst_in(rst_in), .osc_clk_in(osc_clk_in),
    .backup_supply_in(backup_supply_in), .total_loss_in(total_loss_in),
    .sec_tick_in(sec_tick_in), .alarm0_match_in(alarm0_match_in),
    .alarm1_match_in(alarm1_match_in), .irq_pulse_select_in(irq_pulse_select_in),
    .alarm1_irq_enable_in(alarm1_irq_enable_in), .alarm0_irq_enable_in(alarm0_irq_enable_in),
    .protect_sel_in(protect_sel_in), .status_rd_start_in(status_rd_start_in),
    .status_rd_done_in(status_rd_done_in), .status_wr_in(status_wr_in),
    .status_wdata_in(status_wdata_in), .ccr_wr_in(ccr_wr_in), .arr_wr_in(arr_wr_in),
    .arr_addr_in(arr_addr_in), .status_flags_out(status_flags_out), .wr_done_out(wr_done_out),
    .wr_ack_out(wr_ack_out), .wr_commit_out(wr_commit_out), .irq_out(irq_out),
    .irq_oe_out(irq_oe_out));
  rsai_host_model u_rsai_host_model (.clk_in(clk_in), .status_wr_out(status_wr_in),
    .status_wdata_out(status_wdata_in), .ccr_wr_out(ccr_wr_in), .arr_wr_out(arr_wr_in),
    .arr_addr_out(arr_addr_in), .rd_start_out(status_rd_start_in),
    .rd_done_out(status_rd_done_in));
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_in) begin
    if (wr_done_out === 1'b1) begin
      check(exp_q.size() > 0, 1'b1);
      e = exp_q.pop_front();
      check({wr_ack_out, wr_commit_out & e[2]}, {e[1], e[0] & e[2]});
    end
  end
  // expectation e: commit checked, ack, commit
  task automatic wr(input logic [1:0] k, input logic [7:0] d, input logic [10:0] ad,
                    input logic [2:0] ex);
    exp_q.push_back(ex);
    u_rsai_host_model.xfer(k, d, ad);
  endtask
  task automatic flags(input logic [8:0] ex);
    repeat (3) @(posedge clk_in);
    check({irq_oe_out, status_flags_out}, ex);
  endtask
  task automatic alarm(input logic m0, input logic m1);
    @(posedge osc_clk_in);
    alarm0_match_in <= m0;
    alarm1_match_in <= m1;
    sec_tick_in <= 1'b1;
    @(posedge osc_clk_in);
    {sec_tick_in, alarm0_match_in, alarm1_match_in} <= 3'h0;
    repeat (20) @(posedge clk_in);
  endtask
  function automatic logic prot(input logic [2:0] s, input logic [10:0] ad);
    case (s)
      3'h0: return 1'b0;
      3'h1: return ad >= 11'h600;
      3'h2: return ad >= 11'h400;
      3'h3: return 1'b1;
      default: return ad < (11'h040 << (s - 3'h4));
    endcase
  endfunction
  task automatic final_report;
    if (exp_q.size() != 0) err_total++;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    final_report();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68375));
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    flags(9'h001);
    wr(2'h1, 8'h00, 11'h000, 3'h4);
    wr(2'h2, 8'h00, 11'h123, 3'h4);
    wr(2'h0, 8'h06, 11'h000, 3'h2);
    flags(9'h003);
    wr(2'h1, 8'h00, 11'h000, 3'h6);
    wr(2'h0, 8'h00, 11'h000, 3'h2);
    flags(9'h001);
    wr(2'h0, 8'h02, 11'h000, 3'h2);
    wr(2'h0, 8'h06, 11'h000, 3'h2);
    flags(9'h007);
    wr(2'h1, 8'h00, 11'h000, 3'h7);
    wr(2'h0, 8'hFF, 11'h000, 3'h2);
    flags(9'h006);
    for (int s = 0; s < 8; s++) begin
      protect_sel_in <= s[2:0];
      for (int j = 0; j < 5; j++) begin
        a = (j == 0) ? 11'($urandom) : (j == 1) ? 11'h040 : (j == 2) ? 11'h1FF :
            (j == 3) ? 11'h5FF : 11'h600;
        wr(2'h2, 8'h00, a, {2'h3, !prot(s[2:0], a)});
      end
    end
    backup_supply_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    flags(9'h086);
    backup_supply_in <= 1'b0;
    wr(2'h0, 8'h00, 11'h000, 3'h2);
    flags(9'h000);
    alarm1_match_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    alarm1_match_in <= 1'b0;
    flags(9'h000);
    alarm(1'b1, 1'b0);
    flags(9'h020);
    alarm1_irq_enable_in <= 1'b1;
    alarm(1'b0, 1'b1);
    flags(9'h160);
    u_rsai_host_model.rd(0);
    flags(9'h000);
    alarm(1'b0, 1'b1);
    fork
      u_rsai_host_model.rd(40);
      alarm(1'b1, 1'b0);
    join
    flags(9'h020);
    alarm0_irq_enable_in <= 1'b1;
    flags(9'h120);
    u_rsai_host_model.rd(0);
    flags(9'h000);
    irq_pulse_select_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    n = 0;
    fork
      alarm(1'b1, 1'b1);
      for (int i = 0; i < 2000; i++) begin
        @(posedge clk_in);
        if (irq_oe_out === 1'b1) n++;
      end
    join
    check(n >= 1636 && n <= 1641, 1'b1);
    flags(9'h040);
    u_rsai_host_model.rd(0);
    flags(9'h000);
    irq_pulse_select_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    final_report();
  end
endmodule
